// *** logic/qpm_pkg.sv ***
// -----------------------------------------------------------------------------
// Shared constants and types of the management serial port
// -----------------------------------------------------------------------------
package qpm_pkg;

   // Frame layout, counted in shift clock rising edges.
   localparam int unsigned IDLE_ONES = 32; // Ones that make the line idle.
   localparam int unsigned HDR_BITS = 14; // Header bits after the start pattern.
   localparam int unsigned WORD_BITS = 16; // Bits in one data word.
   localparam int unsigned REGS_PER_CHAN = 11; // Registers reached per channel.
   localparam int unsigned NUM_CHANS = 4; // Channels inside the device.

   // Header bit positions, counted from the first bit after the start pattern.
   localparam logic [3:0] HDR_LAST_ADDR_BIT = 4'hb; // Last register address bit.
   localparam logic [3:0] HDR_TA_FIRST_BIT = 4'hc; // First turnaround bit.
   localparam logic [3:0] HDR_TA_LAST_BIT = 4'hd; // Second turnaround bit.
   localparam logic [3:0] WORD_LAST_BIT = 4'hf; // Last bit of a data word.

   // Field values.
   localparam logic [1:0] OP_READ = 2'h2; // Operation code of a read cycle.
   localparam logic [1:0] OP_WRITE = 2'h1; // Operation code of a write cycle.
   localparam logic [4:0] MULTI_REGAD = 5'h1f; // Address that selects every register.
   localparam logic [3:0] LOW_BLOCK_REGS = 4'h6; // Registers 0 to 5 come first.
   localparam logic [4:0] HIGH_BLOCK_SKIP = 5'h0a; // Gap before registers 16 to 20.
   localparam logic [3:0] LAST_REG_IDX = 4'ha; // Index of the eleventh register.
   localparam logic [1:0] LAST_CHAN = 2'h3; // Highest channel number.
   localparam logic [5:0] ONES_LAST = 6'h1f; // Ones count reached before idle.

   // Control and status registers on the plain port.
   localparam logic [3:0] CSR_CTRL_OFS = 4'h0; // Control: bit 0 enables multiple access.
   localparam logic [3:0] CSR_STAT_OFS = 4'h4; // Status of the serial engine.
   localparam int unsigned CTRL_MULTI_BIT = 0; // Position of the multiple access enable.
   localparam logic CTRL_MULTI_RST = 1'b0; // Multiple access is off after reset.

   // Serial engine states.
   typedef enum logic [2:0] {
      ST_WAIT_IDLE = 3'b000,
      ST_IDLE = 3'b001,
      ST_START = 3'b010,
      ST_HDR = 3'b011,
      ST_DATA = 3'b100
   } qpm_state_t;

   // Decoded header of one frame.
   typedef struct packed {
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] regad;
   } qpm_hdr_t;

   // Request to the management register store.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] chan;
      logic [4:0] addr;
      logic [15:0] wdata;
   } qpm_mreq_t;

endpackage : qpm_pkg

// *** logic/qpm_serial_port.sv ***
// Chosen here: strobed register access and the register offsets.
module qpm_serial_port
   import qpm_pkg::*;
(
   input wire logic ref_clk, // System clock, 100 MHz.
   input wire logic rst_b, // Synchronous reset, active low.
   input wire logic mgmt_clk_in, // Shift clock from the controller.
   input wire logic mgmt_data_in, // Data line as seen at the pin.
   output logic mgmt_data_out, // Value driven onto the data line.
   output logic mgmt_data_oe_b, // Low while the device drives the data line.
   input wire logic [2:0] station_addr_pins, // Upper three device address bits.
   input wire logic irq_request, // Interrupt level from the status logic.
   output logic mgmt_interrupt_out, // Interrupt pin.
   output qpm_mreq_t mreg_req, // Request to the register store.
   input wire logic [15:0] mreg_rdata, // Register data, the cycle after a read.
   input wire logic [3:0] csr_addr, // Control port byte address.
   input wire logic [31:0] csr_wdata, // Control port write data.
   input wire logic csr_wr, // Control port write strobe.
   input wire logic csr_rd, // Control port read strobe.
   output logic [31:0] csr_rdata // Control port read data.
);

   // -------------------------------------------------------------------------
   // Pin synchronisation and shift clock edge detection
   // -------------------------------------------------------------------------
   logic [4:0] pins_s; // Synchronised pin group.
   logic mdc_s; // Synchronised shift clock.
   logic mdio_s; // Synchronised data line.
   logic [2:0] addr_pins_s; // Synchronised address pins.
   logic mdc_prev_r; // Shift clock one cycle ago.
   logic mdc_rise; // A rising shift clock edge was seen.

   // The controller makes the shift clock; it is sampled like any pin.
   qpm_sync #(.W(5)) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .d({station_addr_pins, mgmt_data_in, mgmt_clk_in}),
      .q(pins_s)
   );

   assign mdc_s = pins_s[0];
   assign mdio_s = pins_s[1];
   assign addr_pins_s = pins_s[4:2];
   assign mdc_rise = mdc_s & ~mdc_prev_r;

   // -------------------------------------------------------------------------
   // Engine state
   // -------------------------------------------------------------------------
   qpm_state_t state_r, state_nxt; // Frame position.
   logic [5:0] ones_r, ones_nxt; // Consecutive ones seen while waiting.
   logic [10:0] hdr_r, hdr_nxt; // Header bits shifted in so far.
   logic [3:0] bit_r, bit_nxt; // Bit index inside header or word.
   logic [3:0] word_r, word_nxt; // Register index inside a channel.
   logic [1:0] chan_r, chan_nxt; // Channel being accessed.
   logic [4:0] regad_r, regad_nxt; // Register address of a single access.
   logic act_r, act_nxt; // The frame addresses this device.
   logic rd_r, rd_nxt; // The frame is a read.
   logic multi_r, multi_nxt; // The frame is a multiple access.
   logic [15:0] shift_r, shift_nxt; // Data word shift register.
   logic out_r, out_nxt; // Bit on the data line.
   logic drive_r, drive_nxt; // Device drives the data line.
   logic load_r; // Read data from the store is valid now.
   qpm_mreq_t req_r, req_nxt; // Registered store request.
   logic multi_en_r; // Multiple access enable from the control register.
   logic irq_r; // Registered interrupt pin.
   logic [31:0] csr_rdata_r; // Registered control port read data.

   // -------------------------------------------------------------------------
   // Header decode and register address sequencing
   // -------------------------------------------------------------------------
   qpm_hdr_t hdr_now; // Header including the bit arriving now.
   logic hdr_match; // Upper address bits equal the pins.
   logic hdr_opok; // Operation bits name a read or a write.
   logic hdr_multi; // Header asks for every register and multiple access is enabled.
   logic word_last; // Current word is the last of the frame.
   logic [3:0] word_adv; // Next register index in a burst.
   logic [1:0] chan_adv; // Next channel in a burst.
   logic [4:0] addr_now; // Store address of the current word.
   logic [4:0] addr_adv; // Store address of the next word.
   logic [4:0] addr_first; // Store address of the first word.
   logic [15:0] word_in; // Written word including the bit arriving now.

   // Map a burst index 0..10 onto register addresses 0..5 and 16..20.
   function automatic logic [4:0] reg_of_idx(input logic [3:0] idx);
      logic [4:0] wide;
      wide = {1'b0, idx};
      if (idx < LOW_BLOCK_REGS)
         reg_of_idx = wide;
      else
         reg_of_idx = wide + HIGH_BLOCK_SKIP;
   endfunction : reg_of_idx

   // Bits arrive MSB first: operation, device address, register address.
   assign hdr_now = qpm_hdr_t'({hdr_r, mdio_s});
   assign hdr_match = (hdr_now.phy[4:2] == addr_pins_s);
   assign hdr_opok = (hdr_now.op == OP_READ) || (hdr_now.op == OP_WRITE);
   assign hdr_multi = multi_en_r && (hdr_now.regad == MULTI_REGAD);
   assign word_last = !multi_r || ((word_r == LAST_REG_IDX) && (chan_r == LAST_CHAN));
   assign word_adv = (word_r == LAST_REG_IDX) ? 4'h0 : word_r + 4'h1;
   assign chan_adv = (word_r == LAST_REG_IDX) ? chan_r + 2'h1 : chan_r;
   assign addr_now = multi_r ? reg_of_idx(word_r) : regad_r;
   assign addr_adv = reg_of_idx(word_adv);
   assign addr_first = multi_r ? reg_of_idx(4'h0) : regad_r;
   assign word_in = {shift_r[14:0], mdio_s};

   // -------------------------------------------------------------------------
   // Next-state logic of the serial engine
   // -------------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      ones_nxt = ones_r;
      hdr_nxt = hdr_r;
      bit_nxt = bit_r;
      word_nxt = word_r;
      chan_nxt = chan_r;
      regad_nxt = regad_r;
      act_nxt = act_r;
      rd_nxt = rd_r;
      multi_nxt = multi_r;
      shift_nxt = shift_r;
      out_nxt = out_r;
      drive_nxt = drive_r;
      req_nxt = '0;
      // Read data arrives one cycle after the store request.
      if (load_r)
      begin
         shift_nxt = mreg_rdata;
         out_nxt = mreg_rdata[15];
      end
      if (mdc_rise)
      begin
         unique case (state_r)
            ST_WAIT_IDLE:
            begin
               // Count unbroken ones; a zero starts the count again.
               drive_nxt = 1'b0;
               if (!mdio_s)
                  ones_nxt = 6'h00;
               else if (ones_r == ONES_LAST)
                  state_nxt = ST_IDLE;
               else
                  ones_nxt = ones_r + 6'h01;
            end
            ST_IDLE:
            begin
               // Ones keep the port idle; a zero may open a start pattern.
               drive_nxt = 1'b0;
               if (!mdio_s)
                  state_nxt = ST_START;
            end
            ST_START:
            begin
               // The one that completes the start pattern begins the header.
               if (mdio_s)
               begin
                  state_nxt = ST_HDR;
                  bit_nxt = 4'h0;
               end
            end
            ST_HDR:
            begin
               hdr_nxt = {hdr_r[9:0], mdio_s};
               bit_nxt = bit_r + 4'h1;
               if (bit_r == HDR_LAST_ADDR_BIT)
               begin
                  // Whole address known: decide whether and how to respond.
                  act_nxt = hdr_match && hdr_opok;
                  rd_nxt = (hdr_now.op == OP_READ);
                  multi_nxt = hdr_multi;
                  regad_nxt = hdr_now.regad;
                  chan_nxt = hdr_multi ? 2'h0 : hdr_now.phy[1:0];
                  word_nxt = 4'h0;
               end
               else if (bit_r == HDR_TA_FIRST_BIT)
               begin
                  // Second turnaround bit is driven low on a read.
                  drive_nxt = act_r && rd_r;
                  out_nxt = 1'b0;
               end
               else if (bit_r == HDR_TA_LAST_BIT)
               begin
                  state_nxt = ST_DATA;
                  bit_nxt = 4'h0;
                  req_nxt.rd = act_r && rd_r;
                  req_nxt.chan = chan_r;
                  req_nxt.addr = addr_first;
               end
            end
            ST_DATA:
            begin
               bit_nxt = bit_r + 4'h1;
               if (rd_r)
               begin
                  shift_nxt = {shift_r[14:0], 1'b0};
                  out_nxt = shift_r[14];
               end
               else
                  shift_nxt = word_in;
               if (bit_r == WORD_LAST_BIT)
               begin
                  // Commit a written word to the register it belongs to.
                  req_nxt.wr = act_r && !rd_r;
                  req_nxt.chan = chan_r;
                  req_nxt.addr = addr_now;
                  req_nxt.wdata = word_in;
                  if (word_last)
                  begin
                     // Frame done: release the line and demand new idle.
                     state_nxt = ST_WAIT_IDLE;
                     ones_nxt = 6'h00;
                     drive_nxt = 1'b0;
                  end
                  else
                  begin
                     word_nxt = word_adv;
                     chan_nxt = chan_adv;
                     if (act_r && rd_r)
                     begin
                        // Fetch the next word before its first bit is sampled; the line stays driven meanwhile.
                        req_nxt.rd = 1'b1;
                        req_nxt.wr = 1'b0;
                        req_nxt.chan = chan_adv;
                        req_nxt.addr = addr_adv;
                     end
                  end
               end
               else
                  drive_nxt = act_r && rd_r;
            end
            default:
            begin
               state_nxt = ST_WAIT_IDLE;
               drive_nxt = 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Engine registers
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         state_r <= ST_WAIT_IDLE;
         ones_r <= 6'h00;
         hdr_r <= 11'h000;
         bit_r <= 4'h0;
         word_r <= 4'h0;
         chan_r <= 2'h0;
         regad_r <= 5'h00;
         act_r <= 1'b0;
         rd_r <= 1'b0;
         multi_r <= 1'b0;
         shift_r <= 16'h0000;
         out_r <= 1'b0;
         drive_r <= 1'b0;
         req_r <= '0;
         load_r <= 1'b0;
         mdc_prev_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         ones_r <= ones_nxt;
         hdr_r <= hdr_nxt;
         bit_r <= bit_nxt;
         word_r <= word_nxt;
         chan_r <= chan_nxt;
         regad_r <= regad_nxt;
         act_r <= act_nxt;
         rd_r <= rd_nxt;
         multi_r <= multi_nxt;
         shift_r <= shift_nxt;
         out_r <= out_nxt;
         drive_r <= drive_nxt;
         req_r <= req_nxt;
         load_r <= req_r.rd;
         mdc_prev_r <= mdc_s;
      end
   end

   // The line is released whenever the engine does not drive it.
   assign mgmt_data_out = out_r;
   assign mgmt_data_oe_b = ~drive_r;
   assign mreg_req = req_r;

   // -------------------------------------------------------------------------
   // Interrupt pin
   // -------------------------------------------------------------------------
   // The status logic decides the level; this port only carries it out.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         irq_r <= 1'b0;
      else
         irq_r <= irq_request;
   end

   assign mgmt_interrupt_out = irq_r;

   // -------------------------------------------------------------------------
   // Control port
   // -------------------------------------------------------------------------
   logic sel_ctrl; // Access hits the control register.
   logic sel_stat; // Access hits the status register.
   logic [31:0] stat_word; // Status register contents.
   logic [31:0] rd_word; // Selected read value.

   assign sel_ctrl = (csr_addr == CSR_CTRL_OFS);
   assign sel_stat = (csr_addr == CSR_STAT_OFS);
   assign stat_word = {24'h000000, 1'b0, multi_r, rd_r, act_r, drive_r, state_r};
   assign rd_word = sel_ctrl ? {31'h00000000, multi_en_r} : (sel_stat ? stat_word : 32'h00000000);

   // The enable is shared by all channels and sampled once per header.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         multi_en_r <= CTRL_MULTI_RST;
      else if (csr_wr && sel_ctrl)
         multi_en_r <= csr_wdata[CTRL_MULTI_BIT];
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         csr_rdata_r <= 32'h00000000;
      else if (csr_rd)
         csr_rdata_r <= rd_word;
      else
         csr_rdata_r <= 32'h00000000;
   end

   assign csr_rdata = csr_rdata_r;

endmodule : qpm_serial_port

// *** logic/qpm_sync.sv ***
// -----------------------------------------------------------------------------
// Two flip-flop synchroniser for signals from outside the clock domain
// -----------------------------------------------------------------------------
module qpm_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk, // System clock.
   input wire logic rst_b, // Synchronous reset, active low.
   input wire logic [W-1:0] d, // Asynchronous inputs.
   output logic [W-1:0] q // Synchronised outputs.
);

   logic [W-1:0] meta_r; // First stage, read only by the second stage.

   // Two stages in series; nothing else reads the first one.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         meta_r <= '0;
         q <= '0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : qpm_sync

// *** test/qpm_mgmt_ctl.sv ***
// ---------------------------------------------
// Station management controller model
// ---------------------------------------------
module qpm_mgmt_ctl import qpm_pkg::*; (
   output logic mdc, // Shift clock, still between frames.
   output logic drv, // High while the model drives the line.
   output logic dout, // Value the model drives.
   input wire logic line // Resolved data line.
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] rx_q[$]; // Words seen in the last frame.

   // Idle between frames: clock low, line released.
   initial
   begin
      mdc = 1'b0;
      drv = 1'b0;
      dout = 1'b0;
   end

   // One 125 ns bit: set up in the low half, sample at the rise.
   task automatic bit_t(input logic b, input logic own, output logic seen);
      drv = own;
      dout = b;
      #62.5 mdc = 1'b1;
      seen = line;
      #62.5 mdc = 1'b0;
   endtask : bit_t

   // Ones, start, header, turnaround and words; word k written as wb + k.
   task automatic frame(input int ones, input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] rg, input int nw, input logic [15:0] wb);
      logic [13:0] hdr;
      logic [15:0] w;
      logic [15:0] r;
      logic s;
      logic own;
      hdr = {2'b01, op, phy, rg};
      own = op != OP_READ;
      rx_q.delete();
      for (int i = 0; i < ones; i++)
         bit_t(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--)
         bit_t(hdr[i], 1'b1, s);
      bit_t(1'b1, own, s);
      bit_t(1'b0, own, s);
      for (int k = 0; k < nw; k++)
      begin
         w = wb + k[15:0];
         for (int i = 15; i >= 0; i--)
         begin
            bit_t(w[i], own, s);
            r[i] = s;
         end
         rx_q.push_back(r);
      end
      drv = 1'b0;
      #200;
   endtask : frame
endmodule : qpm_mgmt_ctl

// *** test/qpm_port_checker.sv ***
// ---------------------------------------------
// Port checker of the management serial port
// ---------------------------------------------
module qpm_port_checker
   import qpm_pkg::*;
(
   input wire logic ref_clk, // System clock.
   input wire logic rst_b, // Reset, active low.
   input wire logic mgmt_clk_in, // Shift clock.
   input wire logic mgmt_data_in, // Data line.
   input wire logic mgmt_data_out, // Driven bit.
   input wire logic mgmt_data_oe_b, // Drive enable.
   input wire logic [2:0] station_addr_pins, // Address pins.
   input wire logic irq_request, // Interrupt level.
   input wire logic mgmt_interrupt_out, // Interrupt pin.
   input wire qpm_mreq_t mreg_req, // Store request.
   input wire logic [15:0] mreg_rdata, // Store data.
   input wire logic [3:0] csr_addr, // Control address.
   input wire logic [31:0] csr_wdata, // Control data.
   input wire logic csr_wr, // Write strobe.
   input wire logic csr_rd, // Read strobe.
   input wire logic [31:0] csr_rdata // Read data.
);
   timeunit 1ns;
   timeprecision 100ps;
   logic mdc_q; // Shift clock one cycle ago.
   logic [3:0] since_r; // Cycles since a shift clock rise, saturating.
   logic multi_sh; // Expected multiple access enable.

   // Ages shift clock rises and shadows the control bit.
   always_ff @(posedge ref_clk)
   begin
      mdc_q <= mgmt_clk_in;
      since_r <= (mgmt_clk_in && !mdc_q) ? 4'h0 : (since_r == 4'hf ? since_r : since_r + 4'h1);
      if (!rst_b)
         multi_sh <= CTRL_MULTI_RST;
      else if (csr_wr && csr_addr == CSR_CTRL_OFS)
         multi_sh <= csr_wdata[CTRL_MULTI_BIT];
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   a_reset_quiet: assert property ($rose(rst_b) |-> mgmt_data_oe_b && mreg_req == '0 && !mgmt_interrupt_out)
      else $error("Outputs active after reset.");
   a_irq_follow: assert property ($past(rst_b) |-> mgmt_interrupt_out == $past(irq_request))
      else $error("Interrupt pin does not follow its request.");
   a_csr_quiet: assert property (!$past(csr_rd) || ($past(csr_addr) != CSR_CTRL_OFS
      && $past(csr_addr) != CSR_STAT_OFS) |-> csr_rdata == '0) else $error("Read data not zero.");
   a_ctrl_back: assert property ($past(csr_rd) && $past(csr_addr) == CSR_CTRL_OFS
      |-> csr_rdata[CTRL_MULTI_BIT] == multi_sh) else $error("Enable bit reads wrong.");
   a_req_pulse: assert property (mreg_req.rd || mreg_req.wr |=> !mreg_req.rd && !mreg_req.wr)
      else $error("Store request longer than one cycle.");
   a_req_kind: assert property (!(mreg_req.rd && mreg_req.wr))
      else $error("Read and write requested together.");
   a_req_timed: assert property (mreg_req.rd || mreg_req.wr |-> since_r <= 4'h8)
      else $error("Store request away from a shift clock rise.");
   a_drive_timed: assert property ($changed(mgmt_data_oe_b) |-> since_r <= 4'h8)
      else $error("Drive change away from a shift clock rise.");
   a_wr_undriven: assert property (mreg_req.wr |-> mgmt_data_oe_b && $past(mgmt_data_oe_b, 2))
      else $error("Line driven during a write.");
   a_rd_driving: assert property (mreg_req.rd |-> !$past(mgmt_data_oe_b))
      else $error("Read fetch without prior turnaround drive.");
endmodule : qpm_port_checker

bind qpm_serial_port qpm_port_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .mgmt_clk_in(mgmt_clk_in),
   .mgmt_data_in(mgmt_data_in), .mgmt_data_out(mgmt_data_out), .mgmt_data_oe_b(mgmt_data_oe_b),
   .station_addr_pins(station_addr_pins), .irq_request(irq_request), .mgmt_interrupt_out(mgmt_interrupt_out),
   .mreg_req(mreg_req), .mreg_rdata(mreg_rdata), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
   .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_rdata(csr_rdata));

// *** test/tb.sv ***
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
// ---------------------------------------------
// Bench of the management serial port
// ---------------------------------------------
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import qpm_pkg::*;

   logic ref_clk, rst_b, irq_request, csr_wr, csr_rd, irq_out; // Clock, reset and strobes.
   logic mdc, c_drv, c_dout, line, data_out, oe_b, drove; // Serial side.
   logic [2:0] station_addr_pins; // Address pins.
   logic [3:0] csr_addr; // Control address.
   logic [31:0] csr_wdata, csr_rdata; // Control data.
   logic [15:0] mreg_rdata; // Store answer.
   qpm_mreq_t mreg_req; // Store request.
   logic [6:0] rq[$]; // Logged reads: channel, address.
   logic [22:0] wq[$]; // Logged writes: channel, address, data.
   int n_errors = 0, total_checks = 0;

   // Pull-up when nobody drives the line.
   assign line = !oe_b ? data_out : (c_drv ? c_dout : 1'b1);

   qpm_serial_port dut (.ref_clk(ref_clk), .rst_b(rst_b), .mgmt_clk_in(mdc), .mgmt_data_in(line),
      .mgmt_data_out(data_out), .mgmt_data_oe_b(oe_b), .station_addr_pins(station_addr_pins),
      .irq_request(irq_request), .mgmt_interrupt_out(irq_out), .mreg_req(mreg_req), .mreg_rdata(mreg_rdata),
      .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_rdata(csr_rdata));
   qpm_mgmt_ctl ctl (.mdc(mdc), .drv(c_drv), .dout(c_dout), .line(line));

   // Store content, unique per channel and address.
   function automatic logic [15:0] pat(input logic [1:0] c, input logic [4:0] a);
      return {4'ha, c, a, 5'h15};
   endfunction : pat

   // Register store: answers the cycle after a read, logs requests and drive.
   always @(posedge ref_clk)
   begin
      mreg_rdata <= pat(mreg_req.chan, mreg_req.addr);
      if (mreg_req.rd)
         rq.push_back({mreg_req.chan, mreg_req.addr});
      if (mreg_req.wr)
         wq.push_back({mreg_req.chan, mreg_req.addr, mreg_req.wdata});
      if (!oe_b)
         drove <= 1'b1;
   end

   task automatic csr_w(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      csr_addr <= a;
      csr_wdata <= d;
      csr_wr <= 1'b1;
      @(posedge ref_clk);
      csr_wr <= 1'b0;
   endtask : csr_w

   task automatic csr_r(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      csr_addr <= a;
      csr_rd <= 1'b1;
      @(posedge ref_clk);
      csr_rd <= 1'b0;
      #1 d = csr_rdata;
   endtask : csr_r

   // Control port and interrupt pin.
   task automatic t_csr();
      logic [31:0] d;
      csr_r(CSR_CTRL_OFS, d);
      `CHK("ctrl reset", 1'b0, d[0])
      csr_w(CSR_CTRL_OFS, 32'h1);
      csr_r(CSR_CTRL_OFS, d);
      `CHK("ctrl set", 1'b1, d[0])
      csr_r(4'h8, d);
      `CHK("unmapped", 32'h0, d)
      csr_w(CSR_CTRL_OFS, 32'h0);
      irq_request <= 1'b1;
      @(posedge ref_clk);
      #1 `CHK("irq pin", 1'b1, irq_out)
   endtask : t_csr

   // Start needs 32 ones, and again after each frame.
   task automatic t_idle();
      rq.delete();
      drove = 1'b0;
      ctl.frame(31, OP_READ, {station_addr_pins, 2'h0}, 5'h1, 1, 16'h0);
      `CHK("short idle", 1'b0, drove)
      ctl.frame(32, OP_READ, {station_addr_pins, 2'h0}, 5'h1, 1, 16'h0);
      `CHK("read word", pat(2'h0, 5'h1), ctl.rx_q[0])
      ctl.frame(0, OP_READ, {station_addr_pins, 2'h0}, 5'h2, 1, 16'h0);
      `CHK("no fresh idle", 1, rq.size())
   endtask : t_idle

   // A read on every channel, then a write.
   task automatic t_chan();
      for (int c = 0; c < 4; c++)
      begin
         rq.delete();
         ctl.frame(32, OP_READ, {station_addr_pins, c[1:0]}, 5'h10 + c[4:0], 1, 16'h0);
         `CHK("chan word", pat(c[1:0], 5'h10 + c[4:0]), ctl.rx_q[0])
         `CHK("chan req", {c[1:0], 5'h10 + c[4:0]}, rq[0])
         `CHK("released", 1'b1, oe_b)
      end
      wq.delete();
      drove = 1'b0;
      ctl.frame(32, OP_WRITE, {station_addr_pins, 2'h2}, 5'h4, 1, 16'hc35a);
      `CHK("write req", {2'h2, 5'h4, 16'hc35a}, wq[0])
      `CHK("write count", 1, wq.size())
      `CHK("write undriven", 1'b0, drove)
   endtask : t_chan

   // Foreign address and unused operation codes change nothing.
   task automatic t_refuse();
      logic [1:0] ops[4] = '{OP_READ, OP_WRITE, 2'h0, 2'h3};
      for (int i = 0; i < 4; i++)
      begin
         rq.delete();
         wq.delete();
         drove = 1'b0;
         ctl.frame(32, ops[i], {station_addr_pins ^ (i < 2 ? 3'h1 : 3'h0), 2'h1}, 5'h0, 1, 16'h0);
         `CHK("refused drive", 1'b0, drove)
         `CHK("refused reqs", 0, rq.size() + wq.size())
      end
   endtask : t_refuse

   // All-ones address: single when disabled, ordered burst when enabled.
   task automatic t_multi();
      logic [15:0] rx[$];
      logic [4:0] a;
      logic [1:0] c;
      rq.delete();
      ctl.frame(32, OP_READ, {station_addr_pins, 2'h1}, MULTI_REGAD, 1, 16'h0);
      `CHK("multi off", {2'h1, MULTI_REGAD}, rq[0])
      csr_w(CSR_CTRL_OFS, 32'h1);
      rq.delete();
      wq.delete();
      ctl.frame(32, OP_READ, {station_addr_pins, 2'h0}, MULTI_REGAD, 44, 16'h0);
      rx = ctl.rx_q;
      ctl.frame(32, OP_WRITE, {station_addr_pins, 2'h0}, MULTI_REGAD, 44, 16'h1000);
      `CHK("burst writes", 44, wq.size())
      for (int k = 0; k < 44; k++)
      begin
         c = 2'(k / 11);
         a = 5'(k % 11 < 6 ? k % 11 : k % 11 + 10);
         `CHK("burst rd", pat(c, a), rx[k])
         `CHK("burst req", {c, a}, rq[k])
         `CHK("burst wr", {c, a, 16'h1000 + k[15:0]}, wq[k])
      end
      `CHK("burst released", 1'b1, oe_b)
      csr_w(CSR_CTRL_OFS, 32'h0);
   endtask : t_multi

   task automatic close_out();
      $display("Checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   // 100 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Watchdog beyond the expected 30k cycles.
   initial
   begin
      #800000;
      n_errors++;
      close_out();
   end

   // Reset, then the scenarios.
   initial
   begin
      rst_b = 1'b0;
      irq_request = 1'b0;
      csr_wr = 1'b0;
      csr_rd = 1'b0;
      csr_addr = 4'h0;
      csr_wdata = 32'h0;
      station_addr_pins = 3'h5;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_csr();
      t_idle();
      t_chan();
      t_refuse();
      t_multi();
      close_out();
   end
endmodule : tb
